// ### rtl/vsg_top.sv
// What this block does
// - Each group uses its selected pattern
// - Repeat group pattern by its repetition count
// - Group pattern begins at its start position
// - Mask bit per freeze/resume pair
// - Hold select replaces freeze with hold
// - Sequence line length, up to 8192 pixels
// - Separate 13-bit even and odd lengths
// - Final field line uses its own length
// - Concatenate value 1 merges all toggles
// - Concatenation uses only group A settings
// - Mode 0: A first, others even
// - Mode 1: two-line alternation for all
// - Mode 2: A three-line, others EOEOO
// - Mode 3: A four-line, others two-line
// - Per-group separate last repetition length
// - Per-group final toggle at sequence end
// - 24-bit start polarity word per group
// - Low map word assigns outputs 1-12
// - High map word assigns outputs 13-24
// - Toggle at start plus toggle position
// - 5-bit pattern select per group
// - 13-bit freeze position stops outputs
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "vsg_map.svh"

module vsg_top
	import vsg_pkg::*;
(
	input wire logic CLK, // Pixel clock, 250 MHz
	input wire logic RST_N, // Synchronous reset, active low
	input wire logic CE, // Clock enable, freezes all state when low
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB access phase
	input wire logic PWRITE, // APB direction
	input wire logic [7:0] PADDR, // APB byte address
	input wire logic [31:0] PWDATA, // APB write data
	output logic [31:0] PRDATA, // APB read data
	output logic PREADY, // APB ready
	output logic PSLVERR, // APB error on unmapped address
	input wire logic LINE_SYNC, // Line sync, falling edge starts a line
	input wire logic LAST_LINE, // High during the last line of the field
	input wire vsg_tog_t [3:0] PAT_TOG, // Toggles of the selected patterns
	output logic [3:0][4:0] PAT_SEL, // Pattern selection per group
	output logic [23:0] V_OUT // Vertical clock outputs 1 to 24
);

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [3:0] hold_sel_q, hold_sel_d; // Hold instead of freeze per pair
	logic [3:0] mask_en_q, mask_en_d; // Mask enable per pair
	logic [3:0] concat_q, concat_d; // Group concatenation
	vsg_rep_mode_t rep_mode_q, rep_mode_d; // Repetition alternation
	logic [3:0] last_len_en_q, last_len_en_d; // Last repetition length enable
	logic [3:0] last_tog_en_q, last_tog_en_d; // Final toggle enable
	logic [12:0] len_even_q, len_even_d; // Even line length
	logic [12:0] len_odd_q, len_odd_d; // Odd line length
	logic [12:0] len_final_q, len_final_d; // Last line of field length
	logic [23:0] map_low_q, map_low_d; // Outputs 1-12 group codes
	logic [23:0] map_high_q, map_high_d; // Outputs 13-24 group codes
	logic [3:0][23:0] pol_q, pol_d; // Start polarity per group
	vsg_grp_t [3:0] grp_q, grp_d; // Per-group settings
	vsg_win_t [3:0] win_q, win_d; // Freeze and resume pairs

	// ----------------------------------------------------------------
	// Bus slave state
	// ----------------------------------------------------------------
	logic pready_q, pready_d; // Ready in the access phase
	logic pslverr_q, pslverr_d; // Error answer
	logic [31:0] prdata_q, prdata_d; // Read data
	logic [31:0] rd_val; // Decoded read value
	logic rd_hit; // Address is mapped
	logic wr_go; // Write takes effect this edge

	// ----------------------------------------------------------------
	// Timing state
	// ----------------------------------------------------------------
	logic [12:0] pix_q, pix_d; // Pixel position within the line
	logic sync_q, sync_d; // Last line sync level
	logic [1:0] ln4_q, ln4_d; // Line count modulo 4
	logic [1:0] ln3_q, ln3_d; // Line count modulo 3
	logic [2:0] ln5_q, ln5_d; // Line count modulo 5
	logic [23:0] vout_q, vout_d; // Output levels
	logic [12:0] cur_len; // Length of the current line
	logic new_line; // Line boundary this cycle
	logic [3:0] in_win; // Mask window active per pair
	logic stall; // Pattern engines paused
	logic out_hold; // Outputs keep their level
	logic [3:0] ph_d; // Next toggle phase per group
	logic [3:0][1:0] rep_idx; // Repetition count select per group
	logic concat_on; // Concatenation active
	logic [47:0] map_all; // Group codes of all 24 outputs

	// Byte offset from the start of the group blocks
	logic [7:0] grp_off;
	logic [1:0] grp_num;

	// ----------------------------------------------------------------
	// Register read decode
	// ----------------------------------------------------------------
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		grp_off = PADDR - `VSG_ADDR_GRP_BASE;
		grp_num = grp_off[6:5];
		if (PADDR[1:0] != 2'b00) begin
			rd_hit = 1'b0;
		end else if (PADDR == `VSG_ADDR_CTRL) begin
			rd_val[`VSG_CTRL_HOLD_LSB +: 4] = hold_sel_q;
			rd_val[`VSG_CTRL_MASK_LSB +: 4] = mask_en_q;
			rd_val[`VSG_CTRL_CONCAT_LSB +: 4] = concat_q;
			rd_val[`VSG_CTRL_REPMODE_LSB +: 2] = rep_mode_q;
			rd_val[`VSG_CTRL_LASTLEN_LSB +: 4] = last_len_en_q;
			rd_val[`VSG_CTRL_LASTTOG_LSB +: 4] = last_tog_en_q;
		end else if (PADDR == `VSG_ADDR_LINE_LEN) begin
			rd_val[12:0] = len_even_q;
			rd_val[`VSG_HI_LSB +: 13] = len_odd_q;
		end else if (PADDR == `VSG_ADDR_FINAL_LEN) begin
			rd_val[12:0] = len_final_q;
		end else if (PADDR == `VSG_ADDR_MAP_LOW) begin
			rd_val[23:0] = map_low_q;
		end else if (PADDR == `VSG_ADDR_MAP_HIGH) begin
			rd_val[23:0] = map_high_q;
		end else if (PADDR >= `VSG_ADDR_POL_BASE && PADDR < `VSG_ADDR_STATUS) begin
			rd_val[23:0] = pol_q[2'(PADDR[4:2] - 3'd5)];
		end else if (PADDR == `VSG_ADDR_STATUS) begin
			// Live pixel position and line phase
			rd_val[12:0] = pix_q;
			rd_val[`VSG_HI_LSB +: 2] = ln4_q;
		end else if (PADDR >= `VSG_ADDR_GRP_BASE && PADDR < `VSG_ADDR_MASK_BASE
			&& grp_off[4:2] < 3'd4) begin
			unique case (grp_off[3:2])
				2'd0: begin
					rd_val[4:0] = grp_q[grp_num].pat_sel;
					rd_val[`VSG_HI_LSB +: 13] = grp_q[grp_num].start;
				end
				2'd1: begin
					rd_val[12:0] = grp_q[grp_num].len;
					rd_val[`VSG_HI_LSB +: 13] = grp_q[grp_num].last_len;
				end
				2'd2: begin
					rd_val[12:0] = grp_q[grp_num].rep[0];
					rd_val[`VSG_HI_LSB +: 13] = grp_q[grp_num].rep[1];
				end
				2'd3: begin
					rd_val[12:0] = grp_q[grp_num].rep[2];
					rd_val[`VSG_HI_LSB +: 13] = grp_q[grp_num].rep[3];
				end
			endcase
		end else if (PADDR >= `VSG_ADDR_MASK_BASE && PADDR[7:4] == 4'hC) begin
			rd_val[12:0] = win_q[PADDR[3:2]].freeze;
			rd_val[`VSG_HI_LSB +: 13] = win_q[PADDR[3:2]].resume;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Bus answer and register writes
	// ----------------------------------------------------------------
	// Answer in the first access cycle; writes land on that same edge
	assign wr_go = PSEL & PENABLE & pready_q & PWRITE & ~pslverr_q;

	always_comb begin
		pready_d = PSEL & ~PENABLE;
		pslverr_d = PSEL & ~PENABLE & ~rd_hit;
		prdata_d = (PSEL & ~PENABLE & ~PWRITE) ? rd_val : 32'h0000_0000;
		hold_sel_d = hold_sel_q;
		mask_en_d = mask_en_q;
		concat_d = concat_q;
		rep_mode_d = rep_mode_q;
		last_len_en_d = last_len_en_q;
		last_tog_en_d = last_tog_en_q;
		len_even_d = len_even_q;
		len_odd_d = len_odd_q;
		len_final_d = len_final_q;
		map_low_d = map_low_q;
		map_high_d = map_high_q;
		pol_d = pol_q;
		grp_d = grp_q;
		win_d = win_q;
		if (wr_go) begin
			if (PADDR == `VSG_ADDR_CTRL) begin
				hold_sel_d = PWDATA[`VSG_CTRL_HOLD_LSB +: 4];
				mask_en_d = PWDATA[`VSG_CTRL_MASK_LSB +: 4];
				concat_d = PWDATA[`VSG_CTRL_CONCAT_LSB +: 4];
				rep_mode_d = vsg_rep_mode_t'(PWDATA[`VSG_CTRL_REPMODE_LSB +: 2]);
				last_len_en_d = PWDATA[`VSG_CTRL_LASTLEN_LSB +: 4];
				last_tog_en_d = PWDATA[`VSG_CTRL_LASTTOG_LSB +: 4];
			end else if (PADDR == `VSG_ADDR_LINE_LEN) begin
				len_even_d = PWDATA[12:0];
				len_odd_d = PWDATA[`VSG_HI_LSB +: 13];
			end else if (PADDR == `VSG_ADDR_FINAL_LEN) begin
				len_final_d = PWDATA[12:0];
			end else if (PADDR == `VSG_ADDR_MAP_LOW) begin
				map_low_d = PWDATA[23:0];
			end else if (PADDR == `VSG_ADDR_MAP_HIGH) begin
				map_high_d = PWDATA[23:0];
			end else if (PADDR >= `VSG_ADDR_POL_BASE && PADDR < `VSG_ADDR_STATUS) begin
				pol_d[2'(PADDR[4:2] - 3'd5)] = PWDATA[23:0];
			end else if (PADDR >= `VSG_ADDR_GRP_BASE && PADDR < `VSG_ADDR_MASK_BASE) begin
				unique case (grp_off[3:2])
					2'd0: begin
						grp_d[grp_num].pat_sel = PWDATA[4:0];
						grp_d[grp_num].start = PWDATA[`VSG_HI_LSB +: 13];
					end
					2'd1: begin
						grp_d[grp_num].len = PWDATA[12:0];
						grp_d[grp_num].last_len = PWDATA[`VSG_HI_LSB +: 13];
					end
					2'd2: begin
						grp_d[grp_num].rep[0] = PWDATA[12:0];
						grp_d[grp_num].rep[1] = PWDATA[`VSG_HI_LSB +: 13];
					end
					2'd3: begin
						grp_d[grp_num].rep[2] = PWDATA[12:0];
						grp_d[grp_num].rep[3] = PWDATA[`VSG_HI_LSB +: 13];
					end
				endcase
			end else if (PADDR[7:4] == 4'hC) begin
				// Status word is read only, so its address must not land here
				win_d[PADDR[3:2]].freeze = PWDATA[12:0];
				win_d[PADDR[3:2]].resume = PWDATA[`VSG_HI_LSB +: 13];
			end
		end
	end

	// Registers of the bus slave and configuration
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			hold_sel_q <= 4'h0;
			mask_en_q <= 4'h0;
			concat_q <= `VSG_RST_CONCAT;
			rep_mode_q <= VSG_REP_NONE;
			last_len_en_q <= 4'h0;
			last_tog_en_q <= 4'h0;
			len_even_q <= `VSG_RST_LINE_LEN;
			len_odd_q <= `VSG_RST_LINE_LEN;
			len_final_q <= `VSG_RST_LINE_LEN;
			map_low_q <= 24'h00_0000;
			map_high_q <= 24'h00_0000;
			pol_q <= '0;
			grp_q <= '0;
			win_q <= '0;
		end else if (CE) begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
			hold_sel_q <= hold_sel_d;
			mask_en_q <= mask_en_d;
			concat_q <= concat_d;
			rep_mode_q <= rep_mode_d;
			last_len_en_q <= last_len_en_d;
			last_tog_en_q <= last_tog_en_d;
			len_even_q <= len_even_d;
			len_odd_q <= len_odd_d;
			len_final_q <= len_final_d;
			map_low_q <= map_low_d;
			map_high_q <= map_high_d;
			pol_q <= pol_d;
			grp_q <= grp_d;
			win_q <= win_d;
		end
	end

	// ----------------------------------------------------------------
	// Line timing, alternation counters and masking
	// ----------------------------------------------------------------
	// Test values of concatenation are treated as disabled
	assign concat_on = (concat_q == `VSG_CONCAT_ON);

	always_comb begin
		// Odd lines are those with the low line bit set
		if (LAST_LINE) begin
			cur_len = len_final_q;
		end else begin
			cur_len = ln4_q[0] ? len_odd_q : len_even_q;
		end
		// Greater-or-equal so a length shortened mid-line still wraps at once
		new_line = (sync_q & ~LINE_SYNC) | (pix_q >= cur_len - 13'd1);
		pix_d = new_line ? 13'h0000 : pix_q + 13'd1;
		sync_d = LINE_SYNC;
		ln4_d = new_line ? ln4_q + 2'd1 : ln4_q;
		ln3_d = new_line ? ((ln3_q == 2'd2) ? 2'd0 : ln3_q + 2'd1) : ln3_q;
		ln5_d = new_line ? ((ln5_q == 3'd4) ? 3'd0 : ln5_q + 3'd1) : ln5_q;
		for (int k = 0; k < 4; k++) begin
			in_win[k] = mask_en_q[k] & (pix_q >= win_q[k].freeze)
				& (pix_q < win_q[k].resume);
		end
		// Hold keeps the outputs but lets the pattern run on
		stall = |(in_win & ~hold_sel_q);
		out_hold = |in_win;
		// Count select: group A uses index, B to D use 0 even, 1 odd
		unique case (rep_mode_q)
			VSG_REP_NONE: begin
				rep_idx = '0;
			end
			VSG_REP_TWO: begin
				rep_idx = {4{1'b0, ln4_q[0]}};
			end
			VSG_REP_THREE: begin
				rep_idx = {{3{1'b0, (ln5_q == 3'd1 || ln5_q >= 3'd3)}}, 2'b00};
				rep_idx[0] = ln3_q;
			end
			VSG_REP_FOUR: begin
				rep_idx = {{3{1'b0, ln4_q[0]}}, 2'b00};
				rep_idx[0] = ln4_q;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Per-group pattern engines
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 4; g++) begin : gen_grp
		logic act_q, act_d; // Pattern running
		logic done_q, done_d; // Sequence finished for this line
		logic [12:0] rel_q, rel_d; // Pixel within current repetition
		logic [12:0] rep_q, rep_d; // Current repetition number
		logic ph_q; // Toggle phase
		vsg_grp_t eff; // Settings in force
		logic [12:0] n_rep; // Repetitions this line
		logic [12:0] rel_c, rep_c, len_c; // Current position and length
		logic run, hit, fin, last;

		always_comb begin
			// Under concatenation only group A settings apply
			eff = concat_on ? grp_q[0] : grp_q[g];
			n_rep = (concat_on || g == 0) ? eff.rep[rep_idx[0]]
				: eff.rep[{1'b0, rep_idx[g][0]}];
			rel_c = act_q ? rel_q : 13'h0000;
			rep_c = act_q ? rep_q : 13'h0000;
			run = act_q | (~done_q & (pix_q == eff.start) & (n_rep != 13'h0000));
			last = (rep_c == n_rep - 13'd1);
			len_c = (last & last_len_en_q[concat_on ? 0 : g]) ? eff.last_len : eff.len;
			hit = 1'b0;
			for (int t = 0; t < 4; t++) begin
				// Toggle at start plus toggle position
				hit = hit | (PAT_TOG[g].pos[t] == rel_c);
				if (concat_on) begin
					for (int p = 0; p < 4; p++) begin
						hit = hit | (PAT_TOG[p].pos[t] == rel_c);
					end
				end
			end
			hit = hit & run;
			fin = run & last & (rel_c == len_c - 13'd1)
				& last_tog_en_q[concat_on ? 0 : g];
			act_d = act_q;
			done_d = done_q;
			rel_d = rel_q;
			rep_d = rep_q;
			ph_d[g] = ph_q;
			if (new_line) begin
				act_d = 1'b0;
				done_d = 1'b0;
				rel_d = 13'h0000;
				rep_d = 13'h0000;
				ph_d[g] = 1'b0;
			end else if (run && !stall) begin
				// Freeze pauses the engine so resume carries on
				ph_d[g] = ph_q ^ hit ^ fin;
				act_d = 1'b1;
				if (rel_c == len_c - 13'd1) begin
					rel_d = 13'h0000;
					rep_d = rep_c + 13'd1;
					if (last) begin
						act_d = 1'b0;
						done_d = 1'b1;
					end
				end else begin
					rel_d = rel_c + 13'd1;
					rep_d = rep_c;
				end
			end
		end

		// Engine registers
		always_ff @(posedge CLK) begin
			if (!RST_N) begin
				act_q <= 1'b0;
				done_q <= 1'b0;
				rel_q <= 13'h0000;
				rep_q <= 13'h0000;
				ph_q <= 1'b0;
			end else if (CE) begin
				act_q <= act_d;
				done_q <= done_d;
				rel_q <= rel_d;
				rep_q <= rep_d;
				ph_q <= ph_d[g];
			end
		end
	end

	// ----------------------------------------------------------------
	// Output mapping
	// ----------------------------------------------------------------
	assign map_all = {map_high_q, map_low_q};

	always_comb begin
		vout_d = vout_q;
		for (int i = 0; i < 24; i++) begin
			logic [1:0] code;
			code = map_all[2 * i +: 2];
			if (!out_hold) begin
				vout_d[i] = (concat_on ? pol_q[0][i] : pol_q[code][i]) ^ ph_d[code];
			end
		end
	end

	// Timing and output registers
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			pix_q <= 13'h0000;
			sync_q <= 1'b0;
			ln4_q <= 2'd0;
			ln3_q <= 2'd0;
			ln5_q <= 3'd0;
			vout_q <= 24'h00_0000;
		end else if (CE) begin
			pix_q <= pix_d;
			sync_q <= sync_d;
			ln4_q <= ln4_d;
			ln3_q <= ln3_d;
			ln5_q <= ln5_d;
			vout_q <= vout_d;
		end
	end

	// Outputs straight from flip-flops
	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign V_OUT = vout_q;
	always_comb begin
		for (int g = 0; g < 4; g++) begin
			PAT_SEL[g] = grp_q[g].pat_sel;
		end
	end

endmodule : vsg_top

// ### rtl/vsg_map.svh
`ifndef VSG_MAP_SVH
`define VSG_MAP_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define VSG_ADDR_CTRL 8'h00
`define VSG_ADDR_LINE_LEN 8'h04
`define VSG_ADDR_FINAL_LEN 8'h08
`define VSG_ADDR_MAP_LOW 8'h0C
`define VSG_ADDR_MAP_HIGH 8'h10
`define VSG_ADDR_POL_BASE 8'h14
`define VSG_ADDR_STATUS 8'h24
`define VSG_ADDR_GRP_BASE 8'h40
`define VSG_GRP_STRIDE 8'h20
`define VSG_ADDR_MASK_BASE 8'hC0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VSG_CTRL_HOLD_LSB 0
`define VSG_CTRL_MASK_LSB 4
`define VSG_CTRL_CONCAT_LSB 8
`define VSG_CTRL_REPMODE_LSB 12
`define VSG_CTRL_LASTLEN_LSB 16
`define VSG_CTRL_LASTTOG_LSB 20
`define VSG_HI_LSB 16

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define VSG_RST_LINE_LEN 13'h1FFF
`define VSG_RST_CONCAT 4'h0
`define VSG_CONCAT_ON 4'h1
`define VSG_MAX_PIXELS 8192

`endif

// ### rtl/vsg_pkg.sv
package vsg_pkg;

	// Toggle positions of one stored vertical pattern
	typedef struct packed {
		logic [3:0][12:0] pos;
	} vsg_tog_t;

	// Settings of one group of a vertical sequence
	typedef struct packed {
		logic [4:0] pat_sel;
		logic [12:0] start;
		logic [12:0] len;
		logic [12:0] last_len;
		logic [3:0][12:0] rep;
	} vsg_grp_t;

	// Freeze and resume pixel pair
	typedef struct packed {
		logic [12:0] freeze;
		logic [12:0] resume;
	} vsg_win_t;

	// Repetition alternation modes
	typedef enum logic [1:0] {
		VSG_REP_NONE = 2'b00,
		VSG_REP_TWO = 2'b01,
		VSG_REP_THREE = 2'b10,
		VSG_REP_FOUR = 2'b11
	} vsg_rep_mode_t;

endpackage : vsg_pkg

// ### verif/vsg_pat_store.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Pattern store stand-in
// ----------------------------------------------------------------
// Pattern p toggles at p+1, p+5, p+9 and p+13. Patterns 0 to 3 never
// share a position, so a merged pattern has no ambiguous double toggles.
module vsg_pat_store
	import vsg_pkg::*;
(
	input wire logic [3:0][4:0] PAT_SEL, // Selected pattern per group
	output vsg_tog_t [3:0] PAT_TOG // Toggle positions per group
);
	// Answers at once; the block registers its selection itself
	always_comb begin
		for (int g = 0; g < 4; g++) begin
			for (int k = 0; k < 4; k++) begin
				PAT_TOG[g].pos[k] = 13'(PAT_SEL[g]) + 13'(4 * k + 1);
			end
		end
	end
endmodule : vsg_pat_store

// ### verif/vsg_top_sva.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Port checker for the vertical sequence block
// ----------------------------------------------------------------
module vsg_top_sva
	import vsg_pkg::*;
(
	input wire logic CLK, // Pixel clock
	input wire logic RST_N, // Synchronous reset, active low
	input wire logic CE, // Clock enable
	input wire logic PSEL, // Bus select
	input wire logic PENABLE, // Bus access phase
	input wire logic PWRITE, // Bus direction
	input wire logic [7:0] PADDR, // Bus address
	input wire logic [31:0] PWDATA, // Bus write data
	input wire logic [31:0] PRDATA, // Bus read data
	input wire logic PREADY, // Bus ready
	input wire logic PSLVERR, // Bus error
	input wire logic LINE_SYNC, // Line sync
	input wire logic LAST_LINE, // Last line of field
	input wire vsg_tog_t [3:0] PAT_TOG, // Pattern toggles
	input wire logic [3:0][4:0] PAT_SEL, // Pattern selection
	input wire logic [23:0] V_OUT // Vertical outputs
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// Bus answers one cycle after a taken setup, never later
	a_ready_after_setup: assert property (PSEL && !PENABLE && CE |=> PREADY)
		else $error("ready missing after setup");
	a_ready_one_pulse: assert property (PREADY && CE |=> !PREADY)
		else $error("ready longer than one cycle");
	a_ready_needs_setup: assert property (PREADY |-> $past(PSEL && !PENABLE))
		else $error("ready without setup");
	a_error_with_ready: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
		else $error("error without ready or with data");
	// Read data is quiet outside read answers, so stale data never leaks
	a_rdata_quiet: assert property (!PREADY || PWRITE |-> PRDATA == 32'h0)
		else $error("read data outside a read answer");
	a_reset_clears: assert property ($rose(RST_N) |-> V_OUT == 24'h0 && PAT_SEL == 20'h0)
		else $error("outputs not cleared by reset");
	a_select_by_write: assert property (
		!$stable(PAT_SEL) |-> $past(PSEL && PENABLE && PWRITE && PREADY && CE))
		else $error("pattern selection changed without a write");
	a_freeze_no_ce: assert property (!CE |=> $stable(V_OUT) && $stable(PREADY))
		else $error("state moved while clock enable low");
	a_vout_needs_ce: assert property (!$stable(V_OUT) |-> $past(CE))
		else $error("outputs moved without clock enable");
endmodule : vsg_top_sva

bind vsg_top vsg_top_sva u_sva (.CLK(CLK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .LINE_SYNC(LINE_SYNC), .LAST_LINE(LAST_LINE),
	.PAT_TOG(PAT_TOG), .PAT_SEL(PAT_SEL), .V_OUT(V_OUT));

// ### verif/ccd_vertical_sequence_gen_tb.sv
`timescale 1ns/100ps
module ccd_vertical_sequence_gen_tb;
	import vsg_pkg::*;
	// One line case: mode, A counts, B-D even/odd counts, mask, last length, final toggle, merge
	typedef struct packed {
		logic [1:0] mode;
		logic [3:0][12:0] ra;
		logic [12:0] be;
		logic [12:0] bo;
		logic [1:0] msk; // 0 none, 1 freeze, 2 hold
		logic [3:0] ll;
		logic [3:0] lt;
		logic cat;
	} vsg_row_t;
	localparam logic [51:0] RA = {13'd1, 13'd3, 13'd2, 13'd1};
	localparam logic [51:0] RE = {4{13'd2}};
	vsg_row_t rows [8] = '{
		'{2'd0, RA, 13'd1, 13'd2, 2'd0, 4'h0, 4'h0, 1'b0},
		'{2'd1, RA, 13'd1, 13'd2, 2'd0, 4'h0, 4'h0, 1'b0},
		'{2'd2, RA, 13'd1, 13'd2, 2'd0, 4'h0, 4'h0, 1'b0},
		'{2'd3, RA, 13'd1, 13'd2, 2'd0, 4'h0, 4'h0, 1'b0},
		'{2'd0, RE, 13'd2, 13'd2, 2'd1, 4'h0, 4'h0, 1'b0},
		'{2'd0, RE, 13'd2, 13'd2, 2'd2, 4'h0, 4'h0, 1'b0},
		'{2'd1, RA, 13'd1, 13'd2, 2'd0, 4'h5, 4'hF, 1'b0},
		'{2'd0, RE, 13'd1, 13'd1, 2'd0, 4'h0, 4'h0, 1'b1}};
	logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, line_sync, last_line;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, s;
	logic e;
	logic [23:0] v0;
	vsg_tog_t [3:0] pat_tog;
	logic [3:0][4:0] pat_sel;
	logic [23:0] v_out;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	int p, q, lines;
	vsg_top dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .LINE_SYNC(line_sync), .LAST_LINE(last_line), .PAT_TOG(pat_tog),
		.PAT_SEL(pat_sel), .V_OUT(v_out));
	vsg_pat_store u_store (.PAT_SEL(pat_sel), .PAT_TOG(pat_tog));
	// ----------------------------------------------------------------
	// Clock, hang guard and helpers
	// ----------------------------------------------------------------
	always #2 clk = ~clk;
	// A hang counts against the run instead of stalling it
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Entered at a rising edge; request held until ready is seen high
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r,
		output logic er);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait that never sees ready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] r;
		logic er;
		apb(1'b1, a, d, r, er);
	endtask : wr
	task automatic rd(logic [7:0] a, logic [31:0] exp, logic eexp);
		logic [31:0] r;
		logic er;
		apb(1'b0, a, 32'h0, r, er);
		check("prdata", r, exp);
		check("pslverr", {31'h0, er}, {31'h0, eexp});
	endtask : rd
	// Expected outputs after pixel n of line k since reset; window 18..25 pauses or holds
	function automatic logic [23:0] want(vsg_row_t r, int n, int k);
		logic [23:0] v, pl;
		int ef, gs, rep, c, st;
		ef = (r.msk == 0 || n < 18) ? n : (n < 26) ? 17 : (r.msk == 2) ? n : n - 8;
		for (int o = 0; o < 24; o++) begin
			gs = r.cat ? 0 : o % 4;
			st = 2 + gs;
			pl = {8{3'(gs + 1)}};
			if (gs == 0)
				rep = r.ra[r.mode == 1 ? k % 2 : r.mode == 2 ? k % 3 : r.mode == 3 ? k % 4 : 0];
			else if (r.mode == 2)
				rep = (k % 5 == 1 || k % 5 >= 3) ? r.bo : r.be;
			else
				rep = (r.mode != 0 && k % 2 == 1) ? r.bo : r.be;
			c = 0;
			for (int i = 0; i < rep; i++)
				for (int g = 0; g < 4; g++)
					for (int k = 0; k < 4; k++)
						c += int'((r.cat || g == gs) && st + i * 20 + g + 4 * k + 1 <= ef);
			if (r.lt[gs] && rep > 0)
				c += int'(st + (rep - 1) * 20 + (r.ll[gs] ? 18 : 20) - 1 <= ef);
			v[o] = pl[o] ^ c[0];
		end
		return v;
	endfunction : want
	// Starts a line with a sync fall and logs the outputs of its first 64 pixels
	task automatic run_line(vsg_row_t r);
		logic [23:0] lg [64];
		logic [31:0] st;
		logic er;
		lines++;
		line_sync <= 1'b0;
		fork
			for (int j = 0; j < 64; j++) begin
				@(posedge clk);
				#1 lg[j] = v_out;
			end
			begin
				repeat (3) @(posedge clk);
				apb(1'b0, 8'h24, 32'h0, st, er);
			end
		join
		line_sync <= 1'b1;
		check("line_phase", {30'h0, st[17:16]}, 32'(lines % 4));
		for (int j = 2; j < 64; j++)
			if (r.msk == 0 || !((j - 1) inside {[17:19], [25:27]}))
				check("v_out", {8'h0, lg[j]}, {8'h0, want(r, j - 1, lines)});
		@(posedge clk);
	endtask : run_line
	task automatic summarize();
		if (miscompares == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		ce = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		line_sync = 1'b1;
		last_line = 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(8'h04, 32'h1FFF1FFF, 1'b0);
		rd(8'h00, 32'h0, 1'b0);
		rd(8'h50, 32'h0, 1'b1);
		// Lengths stay at their maximum, so only sync falls begin lines and the bench counts them
		wr(8'h0C, 32'h00E4E4E4);
		wr(8'h10, 32'h00E4E4E4);
		wr(8'hC0, 32'h001A0012);
		for (int g = 0; g < 4; g++) begin
			wr(8'(8'h40 + 32 * g), {3'b0, 13'(2 + g), 11'b0, 5'(g)});
			wr(8'(8'h44 + 32 * g), 32'h00120014);
			wr(8'(8'h14 + 4 * g), {8'h0, {8{3'(g + 1)}}});
		end
		rd(8'h0C, 32'h00E4E4E4, 1'b0);
		check("pat_sel", {12'h0, pat_sel}, {12'h0, 5'd3, 5'd2, 5'd1, 5'd0});
		// Table cases, four lines each to visit every line phase
		foreach (rows[i]) begin
			wr(8'h00, {8'h0, rows[i].lt, rows[i].ll, 2'b0, rows[i].mode, 3'b0, rows[i].cat,
				3'b0, rows[i].msk != 2'd0, 3'b0, rows[i].msk == 2'd2});
			wr(8'h48, {3'b0, rows[i].ra[1], 3'b0, rows[i].ra[0]});
			wr(8'h4C, {3'b0, rows[i].ra[3], 3'b0, rows[i].ra[2]});
			for (int g = 1; g < 4; g++)
				wr(8'(8'h48 + 32 * g), {3'b0, rows[i].bo, 3'b0, rows[i].be});
			repeat (4) run_line(rows[i]);
		end
		// Clock enable low must freeze the outputs mid-line, while toggles are due
		line_sync <= 1'b0;
		repeat (6) @(posedge clk);
		ce <= 1'b0;
		@(posedge clk);
		#1 v0 = v_out;
		repeat (3) @(posedge clk);
		#1 check("v_out_frozen", {8'h0, v_out}, {8'h0, v0});
		ce <= 1'b1;
		line_sync <= 1'b1;
		@(posedge clk);
		// Free-running pixel counter wraps at the line length, final line uses its own
		wr(8'h04, 32'h00140014);
		wr(8'h08, 32'h0000000D);
		for (int m = 0; m < 2; m++) begin
			last_line <= m[0];
			apb(1'b0, 8'h24, 32'h0, s, e);
			q = int'(s[12:0]);
			repeat (10) begin
				apb(1'b0, 8'h24, 32'h0, s, e);
				p = int'(s[12:0]);
				check("pixel_range", 32'(p < (m ? 13 : 20)), 32'h1);
				check("pixel_step", 32'((p - q + (m ? 13 : 20)) % (m ? 13 : 20)), 32'h3);
				q = p;
			end
		end
		summarize();
	end
endmodule : ccd_vertical_sequence_gen_tb
